// ### shared/fdcst_pkg.sv
/*
  constants, state codes and helpers for the sense-and-set-track command block.
  assumes a byte-wide command path from the host and one system clock.
*/
package fdcst_pkg;

  // opcodes
  localparam logic [7:0] OP_SENSE_DRV  = 8'h04;  // drive status query
  localparam logic [7:0] OP_SENSE_INT  = 8'h08;  // interrupt-sense
  localparam logic [7:0] OP_TRK_BASE   = 8'h21;  // track access, write-select masked out
  localparam logic [7:0] OP_TRK_MASK   = 8'hBF;  // drops the write-select bit
  localparam int         WNR_BIT       = 6;      // track_write_select position
  localparam int         BYTESEL_BIT   = 2;      // byte select in second byte
  localparam int         HEAD_BIT      = 2;      // head_select in second byte
  localparam logic [1:0] ARGS_DRV      = 2'h1;   // extra bytes for drive query
  localparam logic [1:0] ARGS_TRK      = 2'h2;   // extra bytes for track access

  // interrupt_status_byte causes: interrupt_code bits 7,6 then seek-end bit 5
  localparam logic [2:0] CAUSE_READY    = 3'h6;  // ready in polling / seek not completed
  localparam logic [2:0] CAUSE_SEEK_OK  = 3'h1;  // normal seek termination
  localparam logic [2:0] CAUSE_SEEK_BAD = 3'h3;  // abnormal seek termination
  localparam logic [7:0] ST0_INVALID    = 8'h80; // interrupt_code of invalid command
  localparam logic [1:0] CNT_ONE        = 2'h1;  // result counts
  localparam logic [1:0] CNT_TWO        = 2'h2;
  localparam logic [1:0] CNT_THREE      = 2'h3;

  // command engine states, one-hot
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_ARG  = 5'h02,
    S_EXEC = 5'h04,
    S_LOAD = 5'h08,
    S_RES  = 5'h10
  } fdcst_state_e;

  // drive select decode: 2 needs four drives or the 2/0 swap, 3 needs four drives
  function automatic logic fdcst_drive_ok(input logic [1:0] ds, input logic four, input logic swap);
    unique case (ds)
      2'h2:    fdcst_drive_ok = four | swap;
      2'h3:    fdcst_drive_ok = four;
      default: fdcst_drive_ok = 1'b1;
    endcase
  endfunction : fdcst_drive_ok

endpackage : fdcst_pkg

// ### hdl/fdcst_track_mem.sv
/*
  present_track_value store: one 16-bit word per drive, byte write enables,
  registered read. assumes the caller never writes and reads conflicting data
  in a way that matters; a read sees the old word in the write cycle.
*/
`timescale 1ns/1ns
module fdcst_track_mem #(
  parameter int DRIVES = 4
) (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_sys_rst,
  input  wire logic                      i_we_lo,   // write low byte
  input  wire logic                      i_we_hi,   // write high byte
  input  wire logic [$clog2(DRIVES)-1:0] i_waddr,
  input  wire logic [15:0]               i_wdata,
  input  wire logic [$clog2(DRIVES)-1:0] i_raddr,
  output      logic [15:0]               o_rdata
);
  // a single drive would leave the address ports without a bit
  if (DRIVES < 2)
  begin : g_drives_chk
    $error("fdcst_track_mem: DRIVES must be at least 2");
  end

  logic [15:0] mem_r [DRIVES];  // no reset: software sets tracks by recalibrate
  logic [15:0] rd_nxt;

  // read data comes from a register
  always_comb
  begin
    rd_nxt = mem_r[i_raddr];
  end

  // storage, byte lanes
  always_ff @(posedge i_sys_clk)
  begin
    if (i_we_lo)
      mem_r[i_waddr][7:0] <= i_wdata[7:0];
    if (i_we_hi)
      mem_r[i_waddr][15:8] <= i_wdata[15:8];
  end

  // read register
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_rdata <= 16'h0000;
    else
      o_rdata <= rd_nxt;
  end
endmodule : fdcst_track_mem

// ### hdl/fdcst_cmd.sv
/*
  command interpreter for drive status query, interrupt-sense and track access.
  assumes the host writes command bytes only while o_cmd_ready is high and
  pulses i_res_read only while o_res_valid is high; other opcodes are invalid.
*/
// How it works
// - drive query: one argument, one drive status byte
// - sense with nothing pending acts invalid
// - sense is one byte, then result phase
// - pending set by poll-ready or seek end
// - first result read clears pending interrupt
// - cause coded in bits 7..5 of status
// - transfer interrupts cleared by any FIFO access
// - sense returns status, track low, optional nibble
// - track access raises no interrupt
// - track access takes three command bytes
// - write-select stores byte, else returns stored
// - byte select plus drive picks one byte
// - drives 2 and 3 need support flags
// - track result equals byte read or written
// - drive query raises no interrupt
// - seek end one step period after last step
`timescale 1ns/1ns
module fdcst_cmd #(
  parameter int TMR_W = 16  // width of the step period count
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_cmd_valid,       // host writes a command byte
  input  wire logic [7:0]       i_cmd_byte,
  input  wire logic             i_res_read,        // host reads the result byte
  input  wire logic             i_extended_track_range,
  input  wire logic             i_four_drives,
  input  wire logic             i_swap_drives,     // drives 2 and 0 exchanged
  input  wire logic [4:0]       i_drv_flags,       // sampled drive status lines
  input  wire logic             i_poll_ready,      // drive ready during polling, pulse
  input  wire logic [1:0]       i_poll_drive,
  input  wire logic             i_last_step,       // final step pulse issued, pulse
  input  wire logic [1:0]       i_seek_drive,
  input  wire logic             i_seek_bad,        // seek ended abnormally
  input  wire logic             i_seek_incomplete, // seek not completed
  input  wire logic [TMR_W-1:0] i_step_period,     // step period in cycles
  input  wire logic             i_trk_upd,         // seek engine writes a track
  input  wire logic [1:0]       i_trk_upd_drive,
  input  wire logic [11:0]      i_trk_upd_val,
  input  wire logic             i_xfer_irq,        // result/transfer interrupt, pulse
  output      logic             o_cmd_ready,       // host_request_flag, write direction
  output      logic             o_res_valid,       // host_request_flag, read direction
  output      logic [7:0]       o_res_byte,
  output      logic [1:0]       o_drv_sel,
  output      logic             o_head_sel,
  output      logic             o_irq
);
  // a one-bit timer cannot count a step period down to its last cycle
  if (TMR_W < 2)
  begin : g_tmr_chk
    $error("fdcst_cmd: TMR_W too small");
  end

  fdcst_pkg::fdcst_state_e st_r, st_nxt;          // engine state
  logic [7:0]  op_r, op_nxt;                      // opcode
  logic [7:0]  a1_r, a1_nxt, a2_r, a2_nxt;        // argument bytes
  logic [1:0]  ai_r, ai_nxt;                      // arguments still owed
  logic [7:0]  r1_r, r1_nxt, r2_r, r2_nxt;        // queued result bytes
  logic [1:0]  rc_r, rc_nxt;                      // result bytes left
  logic        sint_r, sint_nxt;                  // valid sense awaiting first read
  logic        rdy_nxt, rv_nxt, hs_nxt, irq_nxt;
  logic [7:0]  rb_nxt;
  logic [1:0]  ds_nxt;
  logic        pend_r, pend_nxt;                  // sense-requiring interrupt
  logic [2:0]  pc_r, pc_nxt;                      // its cause
  logic [1:0]  pd_r, pd_nxt;                      // its drive
  logic        xf_r, xf_nxt;                      // self-clearing interrupt
  logic        ta_r, ta_nxt;                      // step period timer running
  logic [TMR_W-1:0] tm_r, tm_nxt;
  logic [1:0]  td_r, td_nxt;
  logic [2:0]  tc_r, tc_nxt;
  logic        cmd_take, res_take, clr, fire;
  logic [2:0]  fcause;
  logic [1:0]  fdrv;
  logic        is_drv, is_int, is_trk, track_write_select, drv_ok;
  logic [1:0]  need;
  logic        we_lo, we_hi;
  logic [1:0]  waddr, raddr;
  logic [15:0] wdata, rdata;

  assign cmd_take = i_cmd_valid & o_cmd_ready;
  assign res_take = i_res_read & o_res_valid;
  assign is_drv   = (op_r == fdcst_pkg::OP_SENSE_DRV);
  assign is_int   = (op_r == fdcst_pkg::OP_SENSE_INT);
  assign is_trk   = ((op_r & fdcst_pkg::OP_TRK_MASK) == fdcst_pkg::OP_TRK_BASE);
  assign track_write_select      = op_r[fdcst_pkg::WNR_BIT];
  assign drv_ok   = fdcst_pkg::fdcst_drive_ok(a1_r[1:0], i_four_drives, i_swap_drives);
  assign clr      = res_take & sint_r;

  // argument count per opcode, taken from the byte being accepted
  always_comb
  begin
    if (i_cmd_byte == fdcst_pkg::OP_SENSE_DRV)
      need = fdcst_pkg::ARGS_DRV;
    else if ((i_cmd_byte & fdcst_pkg::OP_TRK_MASK) == fdcst_pkg::OP_TRK_BASE)
      need = fdcst_pkg::ARGS_TRK;
    else
      need = 2'h0;
  end

  // track store ports: seek engine wins, host must not touch tracks mid-seek
  always_comb
  begin
    raddr = is_int ? pd_r : a1_r[1:0];
    we_lo = i_trk_upd;
    we_hi = i_trk_upd;
    waddr = i_trk_upd_drive;
    wdata = {4'h0, i_trk_upd_val};
    if (!i_trk_upd && st_r == fdcst_pkg::S_EXEC && is_trk && track_write_select && drv_ok)
    begin
      we_lo = ~a1_r[fdcst_pkg::BYTESEL_BIT];
      we_hi = a1_r[fdcst_pkg::BYTESEL_BIT];
      waddr = a1_r[1:0];
      wdata = {a2_r, a2_r};
    end
  end

  fdcst_track_mem #(.DRIVES(4)) u_mem (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_we_lo   (we_lo),
    .i_we_hi   (we_hi),
    .i_waddr   (waddr),
    .i_wdata   (wdata),
    .i_raddr   (raddr),
    .o_rdata   (rdata)
  );

  // command engine next state: collect, execute, load results, drain
  always_comb
  begin
    st_nxt = st_r; op_nxt = op_r; a1_nxt = a1_r; a2_nxt = a2_r; ai_nxt = ai_r;
    r1_nxt = r1_r; r2_nxt = r2_r; rc_nxt = rc_r; sint_nxt = sint_r;
    rb_nxt = o_res_byte; rv_nxt = o_res_valid; ds_nxt = o_drv_sel; hs_nxt = o_head_sel;
    unique case (st_r)
      fdcst_pkg::S_IDLE:
        if (cmd_take)
        begin
          op_nxt = i_cmd_byte;
          ai_nxt = need;
          st_nxt = (need == 2'h0) ? fdcst_pkg::S_EXEC : fdcst_pkg::S_ARG;
        end
      fdcst_pkg::S_ARG:
        if (cmd_take)
        begin
          // ai_r counts down the bytes still owed
          // first argument is the drive/byte select byte for both argument commands
          if (ai_r == (is_trk ? fdcst_pkg::ARGS_TRK : fdcst_pkg::ARGS_DRV))
            a1_nxt = i_cmd_byte;
          else
            a2_nxt = i_cmd_byte;                     // third byte, ignored on reads
          ai_nxt = ai_r - 2'h1;
          if (ai_r == 2'h1) st_nxt = fdcst_pkg::S_EXEC;
        end
      fdcst_pkg::S_EXEC:
      begin
        // drive select out one cycle ahead so flags settle before sampling
        ds_nxt = a1_r[1:0];
        hs_nxt = a1_r[fdcst_pkg::HEAD_BIT];
        st_nxt = fdcst_pkg::S_LOAD;
      end
      fdcst_pkg::S_LOAD:
      begin
        st_nxt = fdcst_pkg::S_RES;
        rv_nxt = 1'b1;
        rc_nxt = fdcst_pkg::CNT_ONE;
        rb_nxt = fdcst_pkg::ST0_INVALID;
        if (is_drv && drv_ok)
          rb_nxt = {i_drv_flags, a1_r[fdcst_pkg::HEAD_BIT], a1_r[1:0]};
        else if (is_trk && drv_ok)
          rb_nxt = track_write_select ? a2_r :
                   (a1_r[fdcst_pkg::BYTESEL_BIT] ? rdata[15:8] : rdata[7:0]);
        else if (is_int && pend_r)
        begin
          rb_nxt = {pc_r, 3'h0, pd_r};
          r1_nxt = rdata[7:0];
          r2_nxt = {rdata[11:8], 4'h0};
          rc_nxt = i_extended_track_range ? fdcst_pkg::CNT_THREE : fdcst_pkg::CNT_TWO;
          sint_nxt = 1'b1;
        end
      end
      fdcst_pkg::S_RES:
        if (res_take)
        begin
          sint_nxt = 1'b0;
          rb_nxt = r1_r;
          r1_nxt = r2_r;
          rc_nxt = rc_r - 2'h1;
          if (rc_r == fdcst_pkg::CNT_ONE)
          begin
            rv_nxt = 1'b0;
            st_nxt = fdcst_pkg::S_IDLE;
          end
        end
    endcase
    rdy_nxt = (st_nxt == fdcst_pkg::S_IDLE) || (st_nxt == fdcst_pkg::S_ARG);
  end

  // interrupt next state; step period timer delays the seek-end event
  always_comb
  begin
    ta_nxt = ta_r; tm_nxt = tm_r; td_nxt = td_r; tc_nxt = tc_r;
    fire = 1'b0; fcause = tc_r; fdrv = td_r;
    if (ta_r)
    begin
      if (tm_r <= {{(TMR_W-1){1'b0}}, 1'b1})
      begin
        fire = 1'b1;
        ta_nxt = 1'b0;
      end
      else
        tm_nxt = tm_r - {{(TMR_W-1){1'b0}}, 1'b1};
    end
    if (i_last_step)
    begin
      ta_nxt = 1'b1;
      tm_nxt = i_step_period;
      td_nxt = i_seek_drive;
      tc_nxt = i_seek_incomplete ? fdcst_pkg::CAUSE_READY :
               (i_seek_bad ? fdcst_pkg::CAUSE_SEEK_BAD : fdcst_pkg::CAUSE_SEEK_OK);
    end
    if (i_poll_ready)
    begin
      // a poll-ready event only follows a reset, so no seek can collide in practice
      fire = 1'b1;
      fcause = fdcst_pkg::CAUSE_READY;
      fdrv = i_poll_drive;
    end
    // set wins over the read that clears
    pend_nxt = fire ? 1'b1 : (clr ? 1'b0 : pend_r);
    pc_nxt = fire ? fcause : pc_r;
    pd_nxt = fire ? fdrv : pd_r;
    xf_nxt = i_xfer_irq ? 1'b1 : ((cmd_take | res_take) ? 1'b0 : xf_r);
    irq_nxt = pend_nxt | xf_nxt;
  end

  // registers of both groups
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st_r <= fdcst_pkg::S_IDLE; op_r <= 8'h00; a1_r <= 8'h00; a2_r <= 8'h00; ai_r <= 2'h0;
      r1_r <= 8'h00; r2_r <= 8'h00; rc_r <= 2'h0; sint_r <= 1'b0;
      o_cmd_ready <= 1'b1; o_res_valid <= 1'b0; o_res_byte <= 8'h00;
      o_drv_sel <= 2'h0; o_head_sel <= 1'b0; o_irq <= 1'b0;
      pend_r <= 1'b0; pc_r <= 3'h0; pd_r <= 2'h0; xf_r <= 1'b0;
      ta_r <= 1'b0; tm_r <= '0; td_r <= 2'h0; tc_r <= 3'h0;
    end
    else
    begin
      st_r <= st_nxt; op_r <= op_nxt; a1_r <= a1_nxt; a2_r <= a2_nxt; ai_r <= ai_nxt;
      r1_r <= r1_nxt; r2_r <= r2_nxt; rc_r <= rc_nxt; sint_r <= sint_nxt;
      o_cmd_ready <= rdy_nxt; o_res_valid <= rv_nxt; o_res_byte <= rb_nxt;
      o_drv_sel <= ds_nxt; o_head_sel <= hs_nxt; o_irq <= irq_nxt;
      pend_r <= pend_nxt; pc_r <= pc_nxt; pd_r <= pd_nxt; xf_r <= xf_nxt;
      ta_r <= ta_nxt; tm_r <= tm_nxt; td_r <= td_nxt; tc_r <= tc_nxt;
    end
  end

  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  a_drv_query_one: assert property (st_r == fdcst_pkg::S_LOAD && is_drv && drv_ok |=>
    o_res_valid && rc_r == fdcst_pkg::CNT_ONE && o_res_byte[1:0] == $past(a1_r[1:0]))
    else $error("drive query result wrong");
  a_sense_reject: assert property (st_r == fdcst_pkg::S_LOAD && is_int && !pend_r |=>
    o_res_byte == fdcst_pkg::ST0_INVALID && rc_r == fdcst_pkg::CNT_ONE)
    else $error("sense with nothing pending not rejected");
  a_sense_count: assert property (st_r == fdcst_pkg::S_LOAD && is_int && pend_r |=>
    rc_r == ($past(i_extended_track_range) ? fdcst_pkg::CNT_THREE : fdcst_pkg::CNT_TWO))
    else $error("sense result count wrong");
  a_pend_clear: assert property (clr && !fire |=> !pend_r)
    else $error("pending not cleared by first read");
  a_pend_cause: assert property ($rose(pend_r) |-> $past(fire))
    else $error("pending set without cause");
  a_poll_code: assert property (i_poll_ready |=> pend_r && pc_r == fdcst_pkg::CAUSE_READY)
    else $error("poll-ready cause code wrong");
  a_xfer_clear: assert property (xf_r && (cmd_take || res_take) && !i_xfer_irq |=> !xf_r)
    else $error("transfer interrupt not cleared by access");
  a_trk_result: assert property (st_r == fdcst_pkg::S_LOAD && is_trk && track_write_select && drv_ok
    |=> o_res_byte == $past(a2_r) && rc_r == fdcst_pkg::CNT_ONE)
    else $error("track write result wrong");
  a_trk_write: assert property (we_lo && !i_trk_upd |-> st_r == fdcst_pkg::S_EXEC && track_write_select)
    else $error("track byte written outside write-select");
  a_bad_drive: assert property (st_r == fdcst_pkg::S_LOAD && is_trk && !drv_ok |=>
    o_res_byte == fdcst_pkg::ST0_INVALID)
    else $error("unsupported drive accepted");
  a_seek_delay: assert property (ta_r && tm_r == {{(TMR_W-1){1'b0}}, 1'b1} && !i_last_step
    |=> pend_r ##1 !ta_r || $past(i_last_step))
    else $error("seek end not raised after step period");
  a_back_idle: assert property (st_r == fdcst_pkg::S_RES && res_take && rc_r == fdcst_pkg::CNT_ONE
    |=> o_cmd_ready && !o_res_valid)
    else $error("engine not idle after last result");

  c_sense_etr: cover property (st_r == fdcst_pkg::S_LOAD && is_int && pend_r && i_extended_track_range);
  c_trk_read:  cover property (st_r == fdcst_pkg::S_LOAD && is_trk && !track_write_select && drv_ok);
  c_drv_query: cover property (st_r == fdcst_pkg::S_LOAD && is_drv && drv_ok);
  c_seek_end:  cover property (fire && !i_poll_ready);
endmodule : fdcst_cmd

// ### test/fdcst_host.sv
/*
  host model: writes command bytes and reads result bytes, paced only by the
  two request flags. assumes one task call at a time and a free-running clock.
*/
`timescale 1ns/1ns
module fdcst_host (
  input  wire logic       i_sys_clk,
  input  wire logic       i_cmd_ready,
  input  wire logic       i_res_valid,
  input  wire logic [7:0] i_res_byte,
  output      logic       o_cmd_valid,
  output      logic [7:0] o_cmd_byte,
  output      logic       o_res_read,
  output      logic       o_hang       // a flag never came within the bound
);
  initial
  begin
    o_cmd_valid = 1'b0;
    o_cmd_byte  = 8'h00;
    o_res_read  = 1'b0;
    o_hang      = 1'b0;
  end

  // one command byte; the host polls the flag instead of sensing interrupts
  task automatic wr(input logic [7:0] b);
    int n;
    n = 0;
    @(negedge i_sys_clk);
    while (i_cmd_ready !== 1'b1 && n < 60)
    begin
      n++;
      @(negedge i_sys_clk);
    end
    if (n == 60) o_hang = 1'b1;
    o_cmd_valid = 1'b1;
    o_cmd_byte  = b;
    @(negedge i_sys_clk);
    o_cmd_valid = 1'b0;
    o_cmd_byte  = ~b; // released data shows no stale value
  endtask : wr

  // one result byte, taken at the falling edge that raises the read, before the rising edge samples it
  task automatic rd(output logic [7:0] b);
    int n;
    n = 0;
    @(negedge i_sys_clk);
    while (i_res_valid !== 1'b1 && n < 60)
    begin
      n++;
      @(negedge i_sys_clk);
    end
    if (n == 60) o_hang = 1'b1;
    b          = i_res_byte;
    o_res_read = 1'b1;
    @(negedge i_sys_clk);
    o_res_read = 1'b0;
  endtask : rd
endmodule : fdcst_host

// ### test/tb_top.sv
/*
  self-checking bench for the command block: drives drive status and seek
  events itself, talks through the host model. assumes fdcst_pkg is compiled.
*/
`timescale 1ns/1ns
module tb_top;
  logic        clk    = 1'b0;   // 125 MHz
  logic        rst    = 1'b1;   // async, active high
  logic        extended_track_range    = 1'b0;
  logic        four   = 1'b1;
  logic        swap   = 1'b0;
  logic [4:0]  flags  = 5'h15;
  logic        poll   = 1'b0;
  logic        step   = 1'b0;
  logic        bad    = 1'b0;
  logic        inc    = 1'b0;
  logic        upd    = 1'b0;
  logic        xirq   = 1'b0;
  logic [1:0]  sdrv   = 2'h0;
  logic [15:0] period = 16'h0001;
  logic [11:0] uval   = 12'h000;
  logic        cv, rr, crdy, rv, hs, irq, hang;
  logic [7:0]  cb, rb;
  logic [1:0]  ds;
  int          failures   = 0;
  int          n_compared = 0;

  always #4 clk = ~clk;

  fdcst_host host (.i_sys_clk(clk), .i_cmd_ready(crdy), .i_res_valid(rv), .i_res_byte(rb),
                   .o_cmd_valid(cv), .o_cmd_byte(cb), .o_res_read(rr), .o_hang(hang));

  fdcst_cmd #(.TMR_W(16)) dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_cmd_valid(cv), .i_cmd_byte(cb),
    .i_res_read(rr), .i_extended_track_range(extended_track_range), .i_four_drives(four), .i_swap_drives(swap),
    .i_drv_flags(flags), .i_poll_ready(poll), .i_poll_drive(sdrv), .i_last_step(step),
    .i_seek_drive(sdrv), .i_seek_bad(bad), .i_seek_incomplete(inc), .i_step_period(period),
    .i_trk_upd(upd), .i_trk_upd_drive(sdrv), .i_trk_upd_val(uval), .i_xfer_irq(xirq),
    .o_cmd_ready(crdy), .o_res_valid(rv), .o_res_byte(rb), .o_drv_sel(ds), .o_head_sel(hs),
    .o_irq(irq));

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic get(input string nm, input logic [7:0] e);
    logic [7:0] b;
    host.rd(b);
    chk(nm, e, b);
  endtask : get

  // back in the command phase with nothing left to read
  task automatic idle_chk();
    chk("cmd_ready", 8'h01, {7'h0, crdy});
    chk("res_valid", 8'h00, {7'h0, rv});
  endtask : idle_chk

  task automatic trk(input logic w, input logic h, input logic [1:0] d, input logic [7:0] v);
    host.wr(fdcst_pkg::OP_TRK_BASE | {1'b0, w, 6'h00});
    host.wr({4'h3, 1'b0, h, d});
    host.wr(v);
  endtask : trk

  task automatic t_drv_query();
    host.wr(fdcst_pkg::OP_SENSE_DRV);
    host.wr(8'hF5);
    get("drive_status", {5'h15, 3'h5});
    chk("drv_sel", 8'h01, {6'h0, ds});
    chk("head_sel", 8'h01, {7'h0, hs});
    chk("irq_none", 8'h00, {7'h0, irq});
    idle_chk();
  endtask : t_drv_query

  // sense with nothing pending, and opcodes outside the set
  task automatic t_invalid();
    logic [7:0] ops [3] = '{fdcst_pkg::OP_SENSE_INT, 8'hFF, 8'h00};
    foreach (ops[j])
    begin
      host.wr(ops[j]);
      get("invalid_status", fdcst_pkg::ST0_INVALID);
      idle_chk();
    end
  endtask : t_invalid

  // all eight bytes written, then read back with a dummy third byte
  task automatic t_track();
    logic [7:0] v;
    extended_track_range = 1'b1;
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 8; i++)
      begin
        v = i[2] ? 8'h08 + 8'(i) : 8'hA4 + 8'(i);
        trk(p == 0, i[2], i[1:0], p == 0 ? v : 8'hFF);
        get("track_byte", v);
        chk("irq_none", 8'h00, {7'h0, irq});
      end
    idle_chk();
  endtask : t_track

  // table of {usable, four drives, swap, drive select}
  task automatic t_drv_sel();
    logic [4:0] tab [5] = '{5'h02, 5'h03, 5'h16, 5'h07, 5'h1B};
    foreach (tab[j])
    begin
      four = tab[j][3];
      swap = tab[j][2];
      trk(1'b1, 1'b0, tab[j][1:0], 8'h5D);
      get("drive_decode", tab[j][4] ? 8'h5D : fdcst_pkg::ST0_INVALID);
      idle_chk();
    end
    four = 1'b1;
    swap = 1'b0;
  endtask : t_drv_sel

  // three seek endings and one poll-ready, with and without the third byte
  task automatic t_sense();
    logic [2:0]  cause [4] = '{fdcst_pkg::CAUSE_SEEK_OK, fdcst_pkg::CAUSE_SEEK_BAD,
                               fdcst_pkg::CAUSE_READY, fdcst_pkg::CAUSE_READY};
    logic [11:0] t;
    for (int c = 0; c < 4; c++)
    begin
      t    = 12'h95A + 12'(c * 273);
      extended_track_range  = c[0];
      upd  = 1'b1;
      sdrv = c[1:0];
      uval = t;
      @(negedge clk);
      upd    = 1'b0;
      bad    = (c == 1);
      inc    = (c == 2);
      period = 16'(4 + c);
      if (c < 3) step = 1'b1;
      else poll = 1'b1;
      @(negedge clk);
      step = 1'b0;
      poll = 1'b0;
      // seek end waits a full step period, poll ready does not
      if (c < 3)
        for (int k = 0; k < 4 + c; k++)
        begin
          chk("irq_wait", 8'h00, {7'h0, irq});
          @(negedge clk);
        end
      else
        @(negedge clk);
      chk("irq_set", 8'h01, {7'h0, irq});
      host.wr(fdcst_pkg::OP_SENSE_INT);
      get("sense_status", {cause[c], 3'h0, 2'(c)});
      chk("irq_clear", 8'h00, {7'h0, irq});
      get("sense_track", t[7:0]);
      if (c[0]) get("sense_nibble", {t[11:8], 4'h0});
      idle_chk();
    end
  endtask : t_sense

  // transfer interrupt goes away on the next taken host write
  task automatic t_xfer();
    flags = 5'h0A;
    xirq  = 1'b1;
    @(negedge clk);
    xirq = 1'b0;
    @(negedge clk);
    chk("xfer_irq_set", 8'h01, {7'h0, irq});
    host.wr(fdcst_pkg::OP_SENSE_DRV);
    @(negedge clk);
    chk("xfer_irq_clr", 8'h00, {7'h0, irq});
    host.wr(8'h03);
    get("drive_status", {5'h0A, 3'h3});
    idle_chk();
  endtask : t_xfer

  task automatic tally_and_finish();
    if (hang === 1'b1) failures++;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // cut a hang short well past the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk("reset_irq", 8'h00, {7'h0, irq});
    idle_chk();
    t_drv_query();
    t_invalid();
    t_track();
    t_drv_sel();
    t_sense();
    t_xfer();
    tally_and_finish();
  end
endmodule : tb_top
